// ---- hdl/sas_pkg.sv ----
// Shared constants, register map and mode encoding of the smoke alarm sequencer
package sas_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and slow reference tick
	localparam int CLK_PERIOD_NS = 10;                              // System clock period
	localparam int REF_PERIOD_NS = 10_000;                          // Slow reference tick period
	localparam int REF_DIV       = REF_PERIOD_NS / CLK_PERIOD_NS;   // Clocks per tick
	localparam int REF_PERIOD_US = REF_PERIOD_NS / 1000;            // Tick period in us

	////////////////////////////////////////////////////////////////////////////
	// Sequencer times, in microseconds, and their tick counts
	localparam int T_CYCLE_QUIET_US = 1_650_000;                    // Cycle without smoke
	localparam int T_CYCLE_ALARM_US = 41_670;                       // Cycle during smoke
	localparam int T_STROBE_US      = 10_000;                       // Comparator power strobe
	localparam int T_HORN_PHASE_US  = 500_000;                      // Horn on or off phase
	localparam int T_LED_US         = 11_600;                       // LED load pulse
	localparam int QUIET_TICKS  = T_CYCLE_QUIET_US / REF_PERIOD_US;
	localparam int ALARM_TICKS  = T_CYCLE_ALARM_US / REF_PERIOD_US;
	localparam int STROBE_TICKS = T_STROBE_US / REF_PERIOD_US;
	localparam int HORN_TICKS   = T_HORN_PHASE_US / REF_PERIOD_US;
	localparam int LED_TICKS    = T_LED_US / REF_PERIOD_US;
	localparam int LED_EVERY    = 24;                               // Cycles between LED pulses

	////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [7:0] ADR_CTRL     = 8'h00;                    // Control, read/write
	localparam logic [7:0] ADR_STATUS   = 8'h04;                    // Live state, read only
	localparam logic [7:0] ADR_IRQ_STAT = 8'h08;                    // Sticky events, read only
	localparam logic [7:0] ADR_IRQ_CLR  = 8'h0C;                    // Event clear, write only
	localparam logic [7:0] ADR_IRQ_EN   = 8'h10;                    // Event enable, read/write

	////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int         CTRL_RUN     = 0;                        // Sequencer run enable
	localparam logic       CTRL_RUN_RST = 1'b1;                     // Runs from reset
	localparam int         ST_SMOKE     = 0;                        // Smoke output level
	localparam int         ST_LOWBAT    = 1;                        // Low battery output level
	localparam int         ST_TEST      = 2;                        // Test mode active
	localparam int         ST_HORN      = 3;                        // Horn enable
	localparam int         ST_LED       = 4;                        // LED pulse active
	localparam int         ST_STROBE    = 5;                        // Power strobe active
	localparam int         ST_HYS       = 6;                        // Hysteresis select
	localparam int         IRQ_W        = 3;                        // Number of events
	localparam int         IRQ_SMOKE_ON = 0;                        // Alarm entered
	localparam int         IRQ_SMOKE_OFF = 1;                       // Alarm ended
	localparam int         IRQ_LOWBAT   = 2;                        // Low battery found
	localparam logic [31:0] RD_ZERO     = 32'h0000_0000;            // Unmapped read value

	////////////////////////////////////////////////////////////////////////////
	// Sequencer modes
	typedef enum logic [1:0] {
		MODE_STOP  = 2'b00,                                         // Held idle by software
		MODE_QUIET = 2'b01,                                         // No smoke
		MODE_HORN  = 2'b10,                                         // Smoke, horn sounding
		MODE_PAUSE = 2'b11                                          // Smoke, horn silent
	} sas_mode_e;

endpackage

// ---- hdl/sas_sync3.sv ----
// Three stage pin synchroniser, a change passes once stages two and three agree
`timescale 1ns/1ps
module sas_sync3 #(
	parameter int           W       = 1,                            // Number of pins
	parameter logic [W-1:0] RST_VAL = '0                            // Idle pin levels
) (
	input  wire logic         clk_i,                                // System clock
	input  wire logic         rst_i,                                // Synchronous reset
	input  wire logic [W-1:0] d_i,                                  // Raw pin levels
	output logic      [W-1:0] q_o                                   // Filtered levels
);
	import sas_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [W-1:0] s1;                                           // First stage
		logic [W-1:0] s2;                                           // Second stage
		logic [W-1:0] s3;                                           // Third stage
		logic [W-1:0] q;                                            // Accepted level
	} sas_sync_s;

	sas_sync_s    r;                                                // Registered state
	sas_sync_s    n;                                                // Next state
	logic [W-1:0] q_nxt;                                            // Per bit accepted level

	////////////////////////////////////////////////////////////////////////////
	// Accept a level only when stages two and three agree
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign q_nxt[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
	end

	// Next state
	always_comb begin
		n    = r;
		n.s1 = d_i;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.q  = q_nxt;
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			r <= n;
		end
	end

	assign q_o = r.q;

endmodule

// ---- hdl/sas_top.sv ----
// Smoke alarm timing sequencer with Wishbone registers and interrupt
// Notes on behaviour
// - Quiet cycle lasts 1.65 s
// - Each cycle strobes and samples smoke, with skips
// - Battery checked once every 24 cycles
// - Smoke shortens cycle to 41.67 ms, horn on
// - Horn alternates 500 ms on, 500 ms off
// - Silent phase resamples; clear smoke ends alarm
// - In smoke, no battery alarm; LED 1 Hz
// - Test pin low shows live comparator results
// - Outputs high for smoke or low battery
// - Power strobe lasts about 10 ms
// - LED pulse about every 40 s, checks battery
// - LED pulse lasts 11.6 ms
// - Smoke asserts hysteresis select
// - Alarm ends only in silent horn phase, or at once when software clears run
// - At most one strobe per cycle
`timescale 1ns/1ps
module sas_top #(
	parameter int P_REF_DIV      = sas_pkg::REF_DIV,                // Clocks per slow tick
	parameter int P_QUIET_TICKS  = sas_pkg::QUIET_TICKS,            // Quiet cycle length
	parameter int P_ALARM_TICKS  = sas_pkg::ALARM_TICKS,            // Smoke cycle length
	parameter int P_STROBE_TICKS = sas_pkg::STROBE_TICKS,           // Strobe length
	parameter int P_HORN_TICKS   = sas_pkg::HORN_TICKS,             // Horn phase length
	parameter int P_LED_TICKS    = sas_pkg::LED_TICKS,              // LED pulse length
	parameter int P_LED_EVERY    = sas_pkg::LED_EVERY               // Cycles per LED pulse
) (
	input  wire logic        clk_i,                                 // System clock
	input  wire logic        rst_i,                                 // Synchronous reset
	input  wire logic        wb_cyc_i,                              // Wishbone cycle
	input  wire logic        wb_stb_i,                              // Wishbone strobe
	input  wire logic        wb_we_i,                               // Write enable
	input  wire logic [7:0]  wb_adr_i,                              // Byte address
	input  wire logic [3:0]  wb_sel_i,                              // Byte lanes
	input  wire logic [31:0] wb_dat_i,                              // Write data
	output logic      [31:0] wb_dat_o,                              // Read data
	output logic             wb_ack_o,                              // Acknowledge
	input  wire logic        smoke_cmp_i,                           // Smoke comparator result
	input  wire logic        lowbat_cmp_i,                          // Battery comparator result
	input  wire logic        test_n_i,                              // Test mode, active low
	output logic             smoke_o,                               // High on smoke
	output logic             lowbat_o,                              // High on low battery
	output logic             pwr_strobe_o,                          // Comparator power
	output logic             led_o,                                 // LED driver active
	output logic             horn_en_o,                             // Horn oscillator enable
	output logic             hys_sel_o,                             // Hysteresis select
	output logic             irq_o                                  // Interrupt level
);
	import sas_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Widths and terminal counts
	localparam int DW = $clog2(P_REF_DIV + 1);                      // Divider width
	localparam int CW = $clog2(P_QUIET_TICKS + 1);                  // Cycle counter width
	localparam int HW = $clog2(P_HORN_TICKS + 1);                   // Phase counter width
	localparam int IW = $clog2(P_LED_EVERY + 1);                    // Cycle index width
	localparam logic [DW-1:0] DIV_END    = DW'(P_REF_DIV - 1);
	localparam logic [CW-1:0] QUIET_END  = CW'(P_QUIET_TICKS - 1);
	localparam logic [CW-1:0] ALARM_END  = CW'(P_ALARM_TICKS - 1);
	// Pulses rise at count zero, so they fall once the count reaches their length
	localparam logic [CW-1:0] STROBE_END = CW'(P_STROBE_TICKS);
	localparam logic [CW-1:0] LED_END    = CW'(P_LED_TICKS);
	localparam logic [HW-1:0] HORN_END   = HW'(P_HORN_TICKS - 1);
	localparam logic [IW-1:0] IDX_END    = IW'(P_LED_EVERY - 1);

	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [DW-1:0]     div;                                     // Tick divider
		logic [CW-1:0]     cyc_cnt;                                 // Ticks into cycle
		logic [IW-1:0]     idx;                                     // Cycle index
		logic [HW-1:0]     phase;                                   // Ticks into horn phase
		sas_mode_e         mode;                                    // Sequencer mode
		logic              strobe;                                  // Strobe active
		logic              led;                                     // LED pulse active
		logic              chirp;                                   // Low battery chirp
		logic              lowbat;                                  // Held battery result
		logic              smoke_out;                               // Smoke output flop
		logic              lowbat_out;                              // Battery output flop
		logic              run;                                     // Control run bit
		logic [IRQ_W-1:0]  irq_stat;                                // Sticky events
		logic [IRQ_W-1:0]  irq_en;                                  // Event enables
		logic              ack;                                     // Bus acknowledge
		logic [31:0]       dat;                                     // Bus read data
	} sas_state_s;

	sas_state_s       r;                                            // Registered state
	sas_state_s       n;                                            // Next state
	logic [2:0]       pins_s;                                       // Synchronised pins
	logic             smoke_s;                                      // Smoke comparator
	logic             lowbat_s;                                     // Battery comparator
	logic             test_s;                                       // Test mode, active high
	logic             tick;                                         // Slow tick enable
	logic             alarm;                                        // Smoke mode
	logic             cyc_end;                                      // Last tick of cycle
	logic             req;                                          // New bus request
	logic [IRQ_W-1:0] ev;                                           // Events this clock
	logic [IRQ_W-1:0] clr;                                          // Software clears
	logic [31:0]      rd;                                           // Read mux
	logic [31:0]      status;                                       // Status word

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser
	sas_sync3 #(
		.W       (3),
		.RST_VAL (3'b100)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({test_n_i, lowbat_cmp_i, smoke_cmp_i}),
		.q_o   (pins_s)
	);

	assign smoke_s  = pins_s[0];
	assign lowbat_s = pins_s[1];
	assign test_s   = ~pins_s[2];

	////////////////////////////////////////////////////////////////////////////
	// Status word and read mux
	always_comb begin
		status            = RD_ZERO;
		status[ST_SMOKE]  = r.smoke_out;
		status[ST_LOWBAT] = r.lowbat_out;
		status[ST_TEST]   = test_s;
		status[ST_HORN]   = horn_en_o;
		status[ST_LED]    = r.led;
		status[ST_STROBE] = pwr_strobe_o;
		status[ST_HYS]    = hys_sel_o;
		rd                = RD_ZERO;
		case (wb_adr_i)
			ADR_CTRL: begin
				rd[CTRL_RUN] = r.run;
			end
			ADR_STATUS: begin
				rd = status;
			end
			ADR_IRQ_STAT: begin
				rd[IRQ_W-1:0] = r.irq_stat;
			end
			ADR_IRQ_EN: begin
				rd[IRQ_W-1:0] = r.irq_en;
			end
			default: begin
				rd = RD_ZERO;                                       // Unmapped and clear read zero
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		n       = r;
		ev      = '0;
		clr     = '0;
		// One slow tick drives every interval
		tick    = (r.div == DIV_END);
		n.div   = tick ? '0 : r.div + DW'(1);
		alarm   = (r.mode == MODE_HORN) || (r.mode == MODE_PAUSE);
		// Cycle length chosen by smoke state
		cyc_end = r.cyc_cnt >= (alarm ? ALARM_END : QUIET_END);
		req     = wb_cyc_i && wb_stb_i && !r.ack;

		// Outputs: live in test mode, held results otherwise
		n.smoke_out  = test_s ? smoke_s : alarm;
		n.lowbat_out = test_s ? lowbat_s : r.lowbat;

		if (!r.run) begin
			// Held idle by software
			n.mode    = MODE_STOP;
			n.cyc_cnt = '0;
			n.idx     = '0;
			n.phase   = '0;
			n.strobe  = 1'b0;
			n.led     = 1'b0;
			n.chirp   = 1'b0;
		end else if (r.mode == MODE_STOP) begin
			// Restart without smoke
			n.mode = MODE_QUIET;
		end else if (tick) begin
			n.cyc_cnt = cyc_end ? '0 : r.cyc_cnt + CW'(1);
			// LED slot every 24 cycles, battery slot too
			if (cyc_end) begin
				n.idx = (r.idx == IDX_END) ? '0 : r.idx + IW'(1);
			end
			// Cycle start: LED slot or one strobe
			if (r.cyc_cnt == '0) begin
				if (r.idx == '0) begin
					n.led   = 1'b1;                                 // 1 Hz in smoke
					n.chirp = r.lowbat && !alarm;                   // Chirp with LED
				end else if (!test_s && r.mode != MODE_HORN) begin
					n.strobe = 1'b1;                                // Test bypasses strobing
				end
			end
			// Horn phase timing in smoke
			if (alarm) begin
				if (r.phase == HORN_END) begin
					n.phase = '0;
					n.mode  = (r.mode == MODE_HORN) ? MODE_PAUSE : MODE_HORN;
					// A strobe begun in silence must not run into the sounding phase
					if (r.mode == MODE_PAUSE) begin
						n.strobe = 1'b0;
					end
				end else begin
					n.phase = r.phase + HW'(1);
				end
			end
			// Strobe end samples the smoke comparator
			if (r.strobe && r.cyc_cnt == STROBE_END) begin
				n.strobe = 1'b0;
				case (r.mode)
					MODE_QUIET: begin
						if (smoke_s) begin
							n.mode  = MODE_HORN;                    // Alarm, horn on
							n.phase = '0;
							ev[IRQ_SMOKE_ON] = 1'b1;
						end
					end
					MODE_PAUSE: begin
						if (!smoke_s) begin
							n.mode  = MODE_QUIET;                   // Clear during silence
							n.phase = '0;
							ev[IRQ_SMOKE_OFF] = 1'b1;
						end
					end
					default: begin
						n.mode = n.mode;                            // Horn phase: no sample
					end
				endcase
			end
			// LED end takes the battery result, not in smoke
			if (r.led && r.cyc_cnt == LED_END) begin
				n.led   = 1'b0;
				n.chirp = 1'b0;
				if (!alarm) begin
					n.lowbat = lowbat_s;
					ev[IRQ_LOWBAT] = lowbat_s && !r.lowbat;
				end
			end
		end

		// Bus slave, answers one clock after the request
		n.ack = req;
		if (req && !wb_we_i) begin
			n.dat = rd;
		end
		if (req && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				ADR_CTRL: begin
					n.run = wb_dat_i[CTRL_RUN];
				end
				ADR_IRQ_CLR: begin
					clr = wb_dat_i[IRQ_W-1:0];
				end
				ADR_IRQ_EN: begin
					n.irq_en = wb_dat_i[IRQ_W-1:0];
				end
				default: begin
					clr = '0;                                       // Read only or unmapped
				end
			endcase
		end
		// A new event wins over a clear in the same clock
		n.irq_stat = (r.irq_stat & ~clr) | ev;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r      <= '0;
			r.mode <= MODE_QUIET;
			r.run  <= CTRL_RUN_RST;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign wb_dat_o     = r.dat;
	assign wb_ack_o     = r.ack;
	assign smoke_o      = r.smoke_out;
	assign lowbat_o     = r.lowbat_out;
	assign pwr_strobe_o = r.strobe || test_s;                       // Test powers constantly
	assign led_o        = r.led;
	assign horn_en_o    = (r.mode == MODE_HORN) || r.chirp;         // Horn or chirp
	assign hys_sel_o    = (r.mode == MODE_HORN) || (r.mode == MODE_PAUSE);
	assign irq_o        = |(r.irq_stat & r.irq_en);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_no_strobe_horn: assert property (
		(r.mode == MODE_HORN) |-> !r.strobe)
		else $error("Strobe active while horn sounds");

	chk_cycle_index: assert property (
		r.idx <= IDX_END)
		else $error("Cycle index past battery slot");

	chk_alarm_cycle: assert property (
		(hys_sel_o && $past(hys_sel_o)) |-> r.cyc_cnt <= ALARM_END)
		else $error("Smoke cycle longer than its count");

	chk_quiet_cycle: assert property (
		r.cyc_cnt <= QUIET_END)
		else $error("Quiet cycle longer than its count");

	chk_horn_phase: assert property (
		(r.run && tick && hys_sel_o && r.phase == HORN_END && !(r.strobe && r.cyc_cnt == STROBE_END))
		|=> (r.phase == '0) && (horn_en_o != $past(r.mode == MODE_HORN)))
		else $error("Horn phase did not toggle at its end");

	chk_exit_silent: assert property (
		$fell(hys_sel_o) && r.run |-> $past(r.mode) == MODE_PAUSE)
		else $error("Alarm ended outside silent phase");

	chk_strobe_len: assert property (
		r.strobe |-> r.cyc_cnt <= STROBE_END)
		else $error("Strobe outlived its count");

	chk_led_len: assert property (
		r.led |-> r.cyc_cnt <= LED_END)
		else $error("LED pulse outlived its count");

	chk_no_chirp_smoke: assert property (
		hys_sel_o && !$rose(hys_sel_o) |-> !r.chirp)
		else $error("Battery chirp during smoke");

	chk_test_live: assert property (
		test_s && $past(test_s) |-> smoke_o == $past(smoke_s) && pwr_strobe_o)
		else $error("Test mode output not live");

	chk_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held for two clocks");

endmodule

// ---- verification/sas_partner.sv ----
// Behavioural smoke chamber and battery comparators facing the sequencer
`timescale 1ns/1ps
module sas_partner (
	input  wire logic clk_i,        // System clock
	input  wire logic pwr_strobe_i, // Comparator power from the sequencer
	input  wire logic led_i,        // LED load pulse, also powers the battery check
	input  wire logic smoke_lvl_i,  // Chamber sees smoke
	input  wire logic lowbat_lvl_i, // Battery below trip point
	output logic      smoke_cmp_o,  // Smoke comparator pin
	output logic      lowbat_cmp_o  // Battery comparator pin
);
	logic smoke_last_r  = 1'h0;     // Last smoke pin level
	logic lowbat_last_r = 1'h0;     // Last battery pin level
	////////////////////////////////////////////////////////////////////////////
	// Unpowered comparators toggle, so a late sample never reads a stale result
	always_comb begin
		smoke_cmp_o  = pwr_strobe_i ? smoke_lvl_i : ~smoke_last_r;
		lowbat_cmp_o = (pwr_strobe_i | led_i) ? lowbat_lvl_i : ~lowbat_last_r;
	end
	// Remember pin levels for the idle pattern
	always @(posedge clk_i) begin
		smoke_last_r  <= smoke_cmp_o;
		lowbat_last_r <= lowbat_cmp_o;
	end
endmodule

// ---- verification/test_sas_top.sv ----
// Self-checking bench for the smoke alarm sequencer
`timescale 1ns/1ps
module test_sas_top;
	import sas_pkg::*;
	localparam int SM = 0, LB = 1, ST = 2, LD = 3, HN = 4;     // Output bit positions
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, smoke_cmp, lowbat_cmp, test_n;
	logic        smoke_lvl, lowbat_lvl, wb_ack_o, smoke_o, lowbat_o, pwr_strobe_o;
	logic        led_o, horn_en_o, hys_sel_o, irq_o;
	logic [7:0]  wb_adr;                                        // Bus address
	logic [3:0]  wb_sel;                                        // Byte lanes
	logic [31:0] wb_dat, wb_dat_o;                              // Bus data
	logic [4:0]  outs;                                          // Watched outputs
	int          failures, n_compared;                          // Verdict counters
	assign outs = {horn_en_o, led_o, pwr_strobe_o, lowbat_o, smoke_o};
	localparam int DIV = 2, TQ = 40, TA = 12, TS = 3, TL = 4, TH = 30, EVERY = 4; // Short timing
	sas_top #(.P_REF_DIV(DIV), .P_QUIET_TICKS(TQ), .P_ALARM_TICKS(TA), .P_STROBE_TICKS(TS),
		.P_LED_TICKS(TL), .P_HORN_TICKS(TH), .P_LED_EVERY(EVERY)) dut (.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.smoke_cmp_i(smoke_cmp), .lowbat_cmp_i(lowbat_cmp), .test_n_i(test_n),
		.smoke_o(smoke_o), .lowbat_o(lowbat_o), .pwr_strobe_o(pwr_strobe_o), .led_o(led_o),
		.horn_en_o(horn_en_o), .hys_sel_o(hys_sel_o), .irq_o(irq_o));
	sas_partner env (.clk_i(clk_i), .pwr_strobe_i(pwr_strobe_o), .led_i(led_o),
		.smoke_lvl_i(smoke_lvl), .lowbat_lvl_i(lowbat_lvl), .smoke_cmp_o(smoke_cmp),
		.lowbat_cmp_o(lowbat_cmp));
	////////////////////////////////////////////////////////////////////////////
	// Verdict and shared tasks
	task automatic stop_test();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic hang();
		failures++;
		$display("[ERR] %0t wait ran out", $time);
		stop_test();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One classic cycle, held until ack is seen, released at the next edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
		output logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		{wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat} <= {2'b11, w, 4'hF, a, v};
		do begin
			@(negedge clk_i);
			k++;
		end while (wb_ack_o !== 1'h1 && k < 20);
		if (wb_ack_o !== 1'h1) hang();
		@(posedge clk_i);
		d = wb_dat_o;
		{wb_cyc, wb_stb} <= 2'b00;
	endtask
	// Count clocks until an output reaches a level
	task automatic wt(input int b, input logic v, input int lim, output int n);
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (outs[b] !== v && n < lim);
		if (outs[b] !== v) hang();
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		hang();
	end
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] d;
		int          n, m;
		{rst_i, test_n, wb_cyc, wb_stb, wb_we, smoke_lvl, lowbat_lvl} = 7'b1100000;
		{wb_sel, wb_adr, wb_dat, failures, n_compared} = '0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(1'h0, ADR_CTRL, 32'h0000_0000, d);
		chk(d, 32'h0000_0001);
		wb(1'h0, ADR_IRQ_EN, 32'h0000_0000, d);
		chk(d, 32'h0000_0000);
		wb(1'h0, 8'h14, 32'h0000_0000, d);
		chk(d, 32'h0000_0000);
		// Quiet cycle, strobe and LED timing; let the pulse begun at reset end first
		wt(LD, 1'h0, 20, n);
		wt(LD, 1'h1, 400, n);
		chk(horn_en_o, 1'h0);
		wt(LD, 1'h0, 20, n);
		chk(n, DIV * TL);
		wt(ST, 1'h1, 100, m);
		chk(n + m, DIV * TQ);
		wt(ST, 1'h0, 20, n);
		chk(n, DIV * TS);
		wt(ST, 1'h1, 100, m);
		chk(n + m, DIV * TQ);
		wt(LD, 1'h1, 200, n);
		chk(n, 2 * DIV * TQ);
		// Low battery found at the LED load, interrupt, then chirp
		wt(LD, 1'h0, 20, n);
		@(posedge clk_i);
		lowbat_lvl <= 1'h1;
		wt(LD, 1'h1, 400, n);
		wt(LD, 1'h0, 20, n);
		wt(LB, 1'h1, 10, n);
		wb(1'h0, ADR_IRQ_STAT, 32'h0000_0000, d);
		chk(d, 32'h0000_0004);
		chk(irq_o, 1'h0);
		wb(1'h1, ADR_IRQ_EN, 32'h0000_0004, d);
		@(negedge clk_i);
		chk(irq_o, 1'h1);
		wb(1'h1, ADR_IRQ_CLR, 32'h0000_0004, d);
		@(negedge clk_i);
		chk(irq_o, 1'h0);
		wt(LD, 1'h1, 400, n);
		@(negedge clk_i);
		chk(horn_en_o, 1'h1);
		// Smoke alarm, horn phases, inhibited battery, LED rate
		@(posedge clk_i);
		smoke_lvl <= 1'h1;
		wt(SM, 1'h1, 200, n);
		chk({hys_sel_o, horn_en_o}, 32'h0000_0003);
		wb(1'h0, ADR_STATUS, 32'h0000_0000, d);
		chk(d, 32'h0000_004B);
		@(posedge clk_i);
		lowbat_lvl <= 1'h0;
		wt(HN, 1'h0, 100, n);
		wt(HN, 1'h1, 100, n);
		chk(n, DIV * TH);
		wt(HN, 1'h0, 100, n);
		chk(n, DIV * TH);
		wt(LD, 1'h1, 120, n);
		wt(LD, 1'h0, 20, m);
		wt(LD, 1'h1, 120, n);
		chk(n + m, DIV * TA * EVERY);
		chk(lowbat_o, 1'h1);
		// Smoke clears during horn on, alarm ends in the silent phase
		wt(HN, 1'h1, 100, n);
		@(posedge clk_i);
		smoke_lvl <= 1'h0;
		wt(HN, 1'h0, 100, n);
		chk(smoke_o, 1'h1);
		wt(SM, 1'h0, 60, n);
		repeat (100) begin
			@(negedge clk_i);
			chk(smoke_o | (horn_en_o & ~led_o), 1'h0);
		end
		wt(LD, 1'h1, 400, n);
		wt(LB, 1'h0, 20, n);
		wb(1'h0, ADR_IRQ_STAT, 32'h0000_0000, d);
		chk(d, 32'h0000_0003);
		// Test mode shows live comparators
		@(posedge clk_i);
		{test_n, smoke_lvl} <= 2'b01;
		// Test pin sync, then powered comparator sync, then the output flop
		repeat (10) @(negedge clk_i);
		chk({pwr_strobe_o, smoke_o, lowbat_o}, 32'h0000_0006);
		@(posedge clk_i);
		{smoke_lvl, lowbat_lvl} <= 2'b01;
		repeat (6) @(negedge clk_i);
		chk({pwr_strobe_o, smoke_o, lowbat_o}, 32'h0000_0005);
		@(posedge clk_i);
		{test_n, lowbat_lvl} <= 2'b10;
		// Let the test pin leave the synchroniser before power is watched
		repeat (4) @(posedge clk_i);
		// Sequencer held idle by software
		wb(1'h1, ADR_CTRL, 32'h0000_0000, d);
		repeat (200) begin
			@(negedge clk_i);
			chk({pwr_strobe_o, led_o}, 32'h0000_0000);
		end
		wb(1'h0, ADR_CTRL, 32'h0000_0000, d);
		chk(d, 32'h0000_0000);
		stop_test();
	end
endmodule
